// ==== hdl/sar_pkg.sv ====
// shared constants and types for the sampling converter serial readout
`default_nettype none
package sar_pkg;
	localparam int          RESULT_W      = 16;              // result width, successive approximation steps
	localparam int          FIFO_DEPTH    = 4;               // result buffer depth
	localparam logic [2:0]  LEAD_EDGE     = 3'h5;            // falling edge count that enables the output
	localparam logic [15:0] CODE_ZERO     = 16'h0000;        // zero scale / underrange
	localparam logic [15:0] CODE_MID      = 16'h8000;        // midscale, first trial value
	localparam logic [15:0] CODE_FULL     = 16'hffff;        // full scale minus one step / overrange
	localparam logic [4:0]  LAST_BIT      = 5'h0f;           // index of the most significant bit
	localparam logic [4:0]  BITS_DONE     = 5'h10;           // all result bits shifted

	// conversion engine states
	typedef enum logic [2:0] {
		SAR_TRACK   = 3'b001,
		SAR_CONVERT = 3'b010,
		SAR_PUSH    = 3'b100
	} sar_conv_t;
endpackage : sar_pkg
`default_nettype wire

// ==== hdl/sar_fifo.sv ====
// small valid/ready fifo between the conversion engine and the shifter
`default_nettype none
module sar_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	input  wire logic             sys_clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic [WIDTH-1:0]      outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wrPtr;
		logic [AW-1:0] rdPtr;
		logic [AW:0]   count;
	} sar_fifo_st_t;

	sar_fifo_st_t           st_q;
	sar_fifo_st_t           st_d;
	logic [WIDTH-1:0]       mem [DEPTH];
	logic                   doWr;
	logic                   doRd;

	// handshakes are combinational, data leaves from the storage array
	assign inReady  = (st_q.count != (AW+1)'(DEPTH));
	assign outValid = (st_q.count != '0);
	assign outData  = mem[st_q.rdPtr];
	assign doWr     = inValid & inReady;
	assign doRd     = outValid & outReady;

	// pointer and occupancy update
	always_comb begin
		st_d = st_q;
		if (doWr) begin
			st_d.wrPtr = (st_q.wrPtr == AW'(DEPTH-1)) ? '0 : st_q.wrPtr + 1'b1;
		end
		if (doRd) begin
			st_d.rdPtr = (st_q.rdPtr == AW'(DEPTH-1)) ? '0 : st_q.rdPtr + 1'b1;
		end
		st_d.count = st_q.count + (AW+1)'(doWr) - (AW+1)'(doRd);
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// storage has no reset; it is only read behind a valid count
	always_ff @(posedge sys_clk) begin
		if (doWr) begin
			mem[st_q.wrPtr] <= inData;
		end
	end
endmodule : sar_fifo
`default_nettype wire

// ==== hdl/sar_readout.sv ====
// conversion control and serial readout of the sampling converter
`default_nettype none

// Overview of operation
// - select falling edge samples the input, starts conversion and opens the transfer
// - output released until fifth falling serial clock edge, then driven low lead bit
// - after the lead bit each of the next 16 falling serial clock edges shifts one bit, MSB first; later edges drive zero
// - converter enters low power by itself at the end of every conversion
// - result is 16-bit straight binary, 0000 zero, 8000 midscale, ffff full scale
// - after conversion return to tracking; no pipeline latency, read returns fresh sample
// - successive approximation over 16 binary weighted steps, MSB decided first
module sar_readout (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic        selectN,          // active-low select pin from the host
	input  wire logic        serial_shift_clock, // serial clock pin from the host
	input  wire logic        cmpAbove,         // comparator: sampled input at or above trial level
	output logic [15:0]      trialCode,        // trial word driving the capacitor array
	output logic             sampleHold,       // high: input held, low: tracking
	output logic             powerDown,        // high while the analog core sleeps
	output logic             dataOut,          // serial data output value
	output logic             dataOutEnN        // low while the serial output is driven
);
	// ----------------------------------------------------------------
	// state and local signals
	// ----------------------------------------------------------------
	// every flip-flop of the block except the result buffer's lives in this one record, pin synchronisers included
	typedef struct packed {
		logic [1:0]         selSync;
		logic [1:0]         sclkSync;
		logic               selLast;
		logic               sclkLast;
		logic               active;
		logic [2:0]         fallCnt;
		logic [4:0]         bitCnt;
		logic               shifting;
		logic [15:0]        shiftReg;
		logic               haveWord;
		sar_pkg::sar_conv_t conv;
		logic [4:0]         step;
		logic [15:0]        trial;
		logic [15:0]        result;
		logic               hold;
		logic               sleep;
		logic               dOut;
		logic               dEnN;
	} sar_st_t;

	sar_st_t        st_q;
	sar_st_t        st_d;
	logic           selFall;
	logic           selHigh;
	logic           sclkFall;
	logic           pushValid;
	logic           pushReady;
	logic [15:0]    popData;
	logic           popValid;
	logic           popReady;

	// ----------------------------------------------------------------
	// helper functions
	// ----------------------------------------------------------------
	// one-hot weight of the bit under decision
	function automatic logic [15:0] sar_weight(input logic [4:0] idx);
		sar_weight = 16'h0001 << idx[3:0];
	endfunction : sar_weight

	// trial word with the bit under decision kept when the input is at or above it
	function automatic logic [15:0] keep_trial(
		input logic [15:0] trial,
		input logic [4:0]  idx,
		input logic        above
	);
		keep_trial = above ? trial : (trial & ~sar_weight(idx));
	endfunction : keep_trial

	// high-to-low step between the previous and the current synchronised level
	function automatic logic fell_now(input logic last, input logic now);
		fell_now = last & ~now;
	endfunction : fell_now

	// ----------------------------------------------------------------
	// pin edges and result buffer
	// ----------------------------------------------------------------
	// edges are found only on the second sync stage's output, never the first
	assign selHigh   = st_q.selSync[1];
	assign selFall   = fell_now(st_q.selLast, st_q.selSync[1]);
	assign sclkFall  = fell_now(st_q.sclkLast, st_q.sclkSync[1]);
	assign pushValid = (st_q.conv == sar_pkg::SAR_PUSH);
	assign popReady  = st_q.active & ~st_q.haveWord;

	// a full buffer stalls the engine in its push state instead of dropping a result
	sar_fifo #(
		.WIDTH (sar_pkg::RESULT_W),
		.DEPTH (sar_pkg::FIFO_DEPTH)
	) u_fifo (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.inData   (st_q.result),
		.inValid  (pushValid),
		.inReady  (pushReady),
		.outData  (popData),
		.outValid (popValid),
		.outReady (popReady)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d          = st_q;
		st_d.selSync  = {st_q.selSync[0], selectN};
		st_d.sclkSync = {st_q.sclkSync[0], serial_shift_clock};
		st_d.selLast  = st_q.selSync[1];
		st_d.sclkLast = st_q.sclkSync[1];

		// conversion engine
		unique case (st_q.conv)
			sar_pkg::SAR_TRACK: begin
				if (selFall) begin
					st_d.conv  = sar_pkg::SAR_CONVERT;
					st_d.hold  = 1'b1;                   // freeze the sample at the select edge
					st_d.sleep = 1'b0;
					st_d.step  = sar_pkg::LAST_BIT;
					st_d.trial = sar_pkg::CODE_MID;      // msb trial first
				end
			end
			sar_pkg::SAR_CONVERT: begin
				// keep or drop the trial bit, then try the next lower one
				st_d.trial = keep_trial(st_q.trial, st_q.step, cmpAbove);
				if (st_q.step == '0) begin
					st_d.result = keep_trial(st_q.trial, st_q.step, cmpAbove); // straight binary
					st_d.conv   = sar_pkg::SAR_PUSH;
				end else begin
					st_d.trial = keep_trial(st_q.trial, st_q.step, cmpAbove)
						| sar_weight(st_q.step - 5'h01);
					st_d.step  = st_q.step - 5'h01;
				end
			end
			sar_pkg::SAR_PUSH: begin
				// stalls here if the buffer is full rather than losing a result
				if (pushReady) begin
					st_d.conv  = sar_pkg::SAR_TRACK;     // back to tracking
					st_d.hold  = 1'b0;
					st_d.sleep = 1'b1;                   // sleep until next select
				end
			end
			default: begin
				st_d.conv = sar_pkg::SAR_TRACK;
			end
		endcase

		// serial side: frame opens on the same select edge
		if (selFall) begin
			st_d.active   = 1'b1;
			st_d.fallCnt  = '0;
			st_d.bitCnt   = '0;
			st_d.shifting = 1'b0;
			st_d.haveWord = 1'b0;
		end
		if (st_q.active && popValid && !st_q.haveWord) begin
			st_d.shiftReg = popData;                     // fresh sample of this frame
			st_d.haveWord = 1'b1;
		end
		if (st_q.active && sclkFall && !selHigh) begin
			if (!st_q.shifting) begin
				st_d.fallCnt = st_q.fallCnt + 3'h1;
				if (st_q.fallCnt + 3'h1 == sar_pkg::LEAD_EDGE) begin
					st_d.dEnN     = 1'b0;
					st_d.dOut     = 1'b0;                // low lead bit
					st_d.shifting = 1'b1;
				end
			end else if (st_q.bitCnt != sar_pkg::BITS_DONE) begin
				st_d.dOut     = st_q.shiftReg[sar_pkg::RESULT_W-1]; // msb first
				st_d.shiftReg = {st_q.shiftReg[sar_pkg::RESULT_W-2:0], 1'b0};
				st_d.bitCnt   = st_q.bitCnt + 5'h01;
			end else begin
				st_d.dOut = 1'b0;                        // trailing edges read zero
			end
		end

		// select high releases the line and closes the frame
		if (selHigh) begin
			st_d.active   = 1'b0;
			st_d.shifting = 1'b0;
			st_d.dEnN     = 1'b1;
			st_d.dOut     = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// reset loads constants only; the pin samplers start at the idle-high level
	// so that no false select or clock edge is seen right after reset
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st_q          <= '0;
			st_q.selSync  <= 2'h3;
			st_q.selLast  <= 1'b1;
			st_q.sclkSync <= 2'h3;
			st_q.sclkLast <= 1'b1;
			st_q.conv     <= sar_pkg::SAR_TRACK;
			st_q.sleep    <= 1'b1;
			st_q.dEnN     <= 1'b1;
			st_q.result   <= sar_pkg::CODE_ZERO;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// outputs straight from flip-flops
	assign trialCode  = st_q.trial;
	assign sampleHold = st_q.hold;
	assign powerDown  = st_q.sleep;
	assign dataOut    = st_q.dOut;
	assign dataOutEnN = st_q.dEnN;
endmodule : sar_readout
`default_nettype wire

// ==== test/sar_readout_chk.sv ====
// port checker for the converter readout, bound to its top module
`default_nettype none
module sar_readout_chk (
	input wire logic        sys_clk,
	input wire logic        resetn,
	input wire logic        selectN,
	input wire logic [15:0] trialCode,
	input wire logic        sampleHold,
	input wire logic        powerDown,
	input wire logic        dataOut,
	input wire logic        dataOutEnN
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// the synchroniser costs about three cycles, so four idle samples are allowed before release
	a_idle_released: assert property (selectN [*4] |-> dataOutEnN) else $error("output driven while idle");
	a_quiet_release: assert property (dataOutEnN |-> !dataOut) else $error("released line not low");
	a_lead_low: assert property ($fell(dataOutEnN) |-> !dataOut) else $error("lead bit not low");
	a_late_enable: assert property ($fell(selectN) |-> dataOutEnN [*8]) else $error("enabled too early");
	a_start_conv: assert property ($fell(selectN) |-> ##[2:5] $rose(sampleHold)) else $error("no start");
	a_first_trial: assert property ($rose(sampleHold) |-> trialCode == sar_pkg::CODE_MID && !powerDown)
		else $error("first trial not midscale");
	a_conv_steps: assert property ($rose(sampleHold) |-> ##[16:20] $fell(sampleHold)) else $error("bad length");
	a_sleep_after: assert property ($fell(sampleHold) |-> ##[0:2] powerDown) else $error("no sleep");
	a_bit_holds: assert property ($changed(dataOut) && !dataOutEnN |=> $stable(dataOut) [*6])
		else $error("bit not held");
	c_conv: cover property ($rose(sampleHold));
	c_drive: cover property ($fell(dataOutEnN));
	c_release: cover property ($rose(dataOutEnN));
endmodule : sar_readout_chk
bind sar_readout sar_readout_chk chk (.sys_clk(sys_clk), .resetn(resetn), .selectN(selectN),
	.trialCode(trialCode), .sampleHold(sampleHold), .powerDown(powerDown), .dataOut(dataOut),
	.dataOutEnN(dataOutEnN));
`default_nettype wire

// ==== test/sar_host_model.sv ====
// host serial controller: drives select and shift clock, collects one word per frame
`default_nettype none
module sar_host_model (
	input  wire logic sys_clk,
	input  wire logic dataOut,
	input  wire logic dataOutEnN,
	output var logic  selectN,
	output var logic  sclkPin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic lineSeen;
	// a released line shows the inverse of the last value, so a missing enable corrupts the word
	assign lineSeen = (dataOutEnN === 1'b0) ? dataOut : ~dataOut;
	initial begin
		selectN = 1'b1;
		sclkPin = 1'b1;
	end
	// one frame of 22 falls, four system clocks per phase (400 ns); clock stands high outside frames
	task automatic frame(output logic [15:0] w, output logic lead);
		@(posedge sys_clk);
		selectN <= 1'b0;
		for (int k = 1; k <= 22; k++) begin
			repeat (4) @(posedge sys_clk);
			sclkPin <= 1'b0;
			// capture at the fall: the previous bit has stood for five cycles, hold time is ample
			if (k == 5) lead = (dataOutEnN === 1'b1);
			if (k == 6) lead = lead && (lineSeen === 1'b0);
			if (k > 6) w = {w[14:0], lineSeen};
			repeat (4) @(posedge sys_clk);
			sclkPin <= 1'b1;
		end
		repeat (4) @(posedge sys_clk);
		selectN <= 1'b1;
	endtask : frame
endmodule : sar_host_model
`default_nettype wire

// ==== test/sar_readout_tb.sv ====
// self-checking bench for the converter readout
`default_nettype none
module sar_readout_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sysClk = 1'b0;
	logic        resetN = 1'b0;
	logic [15:0] analogIn = 16'h0000;
	logic        selectN, sclkPin, cmpAbove, sampleHold, powerDown, dataOut, dataOutEnN;
	logic [15:0] trialCode;
	int          failures = 0;
	int          totalChecks = 0;
	always #50 sysClk = ~sysClk;
	// ideal comparator in front of the trial word
	assign cmpAbove = (analogIn >= trialCode);
	sar_readout uut (.sys_clk(sysClk), .resetn(resetN), .selectN(selectN), .serial_shift_clock(sclkPin),
		.cmpAbove(cmpAbove), .trialCode(trialCode), .sampleHold(sampleHold), .powerDown(powerDown),
		.dataOut(dataOut), .dataOutEnN(dataOutEnN));
	sar_host_model host (.sys_clk(sysClk), .dataOut(dataOut), .dataOutEnN(dataOutEnN), .selectN(selectN),
		.sclkPin(sclkPin));
	// bitwise successive approximation against a held level
	function automatic logic [15:0] expect_code(input logic [15:0] level);
		logic [15:0] code;
		code = 16'h0000;
		for (int b = 15; b >= 0; b--) begin
			code[b] = 1'b1;
			if (level < code) code[b] = 1'b0;
		end
		return code;
	endfunction : expect_code
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		totalChecks++;
		if (seen !== want) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, seen, want);
		end
	endtask : check
	task automatic test_done();
		$display("checks %0d failures %0d", totalChecks, failures);
		if (failures == 0 && totalChecks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done
	// corner levels first, then random ones; level flips after conversion to expose stale words
	initial begin
		logic [15:0] got;
		logic        lead;
		logic [15:0] levels [$];
		levels = '{16'h0000, 16'hffff, 16'h8000, 16'h7fff, 16'h0001};
		void'($urandom(32'hf6e155cd));
		repeat (6) levels.push_back(16'($urandom()));
		repeat (20) @(posedge sysClk);
		resetN <= 1'b1;
		repeat (3) @(posedge sysClk);
		foreach (levels[i]) begin
			analogIn <= levels[i];
			@(posedge sysClk);
			fork
				host.frame(got, lead);
				begin
					repeat (40) @(posedge sysClk);
					analogIn <= ~levels[i];
				end
			join
			check({15'h0000, lead}, 16'h0001);
			check(got, expect_code(levels[i]));
			repeat (6) @(posedge sysClk);
			check({15'h0000, dataOutEnN}, 16'h0001);
			check({15'h0000, powerDown}, 16'h0001);
		end
		test_done();
	end
	// about 190 cycles per frame; generous margin before declaring a hang
	initial begin
		repeat (8000) @(posedge sysClk);
		failures++;
		test_done();
	end
endmodule : sar_readout_tb
`default_nettype wire
